// ===== bench/mdr_master.sv
// bus master model: one request per call, or a write then read pair, answer taken with rsp_valid
module mdr_master
    import mdr_pkg::*;
(
    input wire logic mclk,
    output logic req_valid,
    output mdr_pkg::mdr_req_t req,
    input wire logic rsp_valid,
    input wire mdr_pkg::mdr_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial
    begin
        req_valid = 1'b0;
        req = '0;
    end

    // request held for its taking edge, then released with scrambled lines
    task automatic xfer(input logic [7:0] fn, input logic [15:0] ad, input logic [15:0] wd,
                        output logic [15:0] data, output logic [7:0] exc, output bit ok);
        int n = 0;
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= '{func: fn, addr: ad, wdata: wd};
        @(posedge mclk);
        req_valid <= 1'b0;
        req <= ~req; // stale request must not look valid
        #1;
        while (rsp_valid !== 1'b1 && n < 4)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        ok = (rsp_valid === 1'b1);
        data = rsp.data;
        exc = rsp.exc;
    endtask

    // holding write then read of the same address on consecutive edges
    task automatic xfer_wr_rd(input logic [15:0] ad, input logic [15:0] wd,
                              output logic [15:0] data, output bit ok);
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= '{func: FN_WRITE_HOLD, addr: ad, wdata: wd};
        @(posedge mclk);
        req <= '{func: FN_READ_HOLD, addr: ad, wdata: 16'h0000};
        @(posedge mclk);
        req_valid <= 1'b0;
        req <= ~req;
        #1;
        ok = (rsp_valid === 1'b1);
        data = rsp.data;
    endtask
endmodule // mdr_master

// ===== bench/tb_mdr_regmap.sv
// self-checking bench of the drive register map
module tb_mdr_regmap;
    timeunit 1ns;
    timeprecision 1ps;
    import mdr_pkg::*;

    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid;
    mdr_req_t req;
    logic rsp_valid;
    mdr_rsp_t rsp;
    logic [31:0] position = 32'h42c8_8000;
    mdr_state_t state = '0;
    mdr_faults_t faults = '0;
    logic [3:0] din = 4'h0;
    logic [31:0] src_vals [15];
    logic motor_running = 1'b0;
    logic [15:0] cur_sq = 16'h0004;
    logic [3:0] dout_q;
    logic [15:0] rd;
    logic [7:0] rx;
    logic [31:0] v;
    int error_cnt = 0;
    int check_count = 0;
    int st_pos [7] = '{0, 1, 2, 3, 20, 26, 31};

    // 25 MHz clock
    initial
    begin
        forever #20 mclk = ~mclk;
    end

    mdr_master u_mdr_master (.mclk(mclk), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp));

    // servo variant, so the encoder input has no effect and is tied
    mdr_regmap u_mdr_regmap (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp), .position(position), .state(state),
        .faults(faults), .din(din), .src_vals(src_vals), .encoder_fitted(1'b0),
        .motor_running(motor_running), .cur_sq(cur_sq), .dout_q(dout_q));

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, seen);
            error_cnt++;
        end
    endtask

    // one access; a missing answer ends the run
    task automatic acc(input logic [7:0] fn, input logic [15:0] ad, input logic [15:0] wd);
        bit ok;
        u_mdr_master.xfer(fn, ad, wd, rd, rx, ok);
        if (!ok)
        begin
            $display("unexpected answer timeout at %h", ad);
            error_cnt++;
            finish_test();
        end
    endtask

    // 32-bit input word, upper half at the lower address
    task automatic rd32(input logic [15:0] ad, output logic [31:0] w);
        acc(FN_READ_INPUT, ad, 16'h0000);
        w[31:16] = rd;
        acc(FN_READ_INPUT, ad + 16'h0001, 16'h0000);
        w[15:0] = rd;
    endtask

    // write and read back with no idle cycle between them
    task automatic wr_rd(input logic [15:0] ad, input logic [15:0] wd);
        bit ok;
        u_mdr_master.xfer_wr_rd(ad, wd, rd, ok);
        check("hold_b2b_ok", 32'(ok), 32'h1);
        check("hold_b2b", 32'(rd), 32'(wd));
    endtask

    initial
    begin
        for (int i = 0; i < 15; i++)
            src_vals[i] = {16'h1000 + 16'(i), 16'h2000 + 16'(i)};
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        rd32(ADDR_POSITION, v);
        check("position", v, 32'h42c8_8000);
        // each status flag alone lands on its own bit, all else zero
        for (int i = 0; i < 7; i++)
        begin
            @(posedge mclk);
            state <= mdr_state_t'(7'h40 >> i);
            rd32(ADDR_STATUS, v);
            check("status", v, 32'h0000_0001 << st_pos[i]);
        end
        state <= '0;
        // fault walk: short circuit and watchdog skip bit 11
        for (int k = 0; k < 13; k++)
        begin
            @(posedge mclk);
            faults <= mdr_faults_t'(13'h0001 << k);
            rd32(ADDR_FAULT, v);
            check("fault", v, 32'h0000_0001 << (k > 10 ? k + 1 : k));
        end
        @(posedge mclk);
        faults <= '0;
        din <= 4'hf;
        rd32(ADDR_DIN, v);
        check("din_image", v, 32'h0000_000f);
        // each coil on, seen on its pin, by coil read and, for coils 0 and 1 only, in the image
        for (int c = 0; c < 4; c++)
        begin
            acc(FN_WRITE_COIL, ADDR_COIL_BASE + 16'(c), COIL_ON);
            check("dout_on", 32'(dout_q), 32'h1 << c);
            acc(FN_READ_COILS, ADDR_COIL_BASE + 16'(c), 16'h0000);
            check("coil_read", 32'(rd[0]), 32'h1);
            rd32(ADDR_DOUT, v);
            check("dout_image", v, (32'h1 << c) & 32'h3);
            acc(FN_WRITE_COIL, ADDR_COIL_BASE + 16'(c), COIL_OFF);
            check("dout_off", 32'(dout_q), 32'h0);
        end
        acc(FN_WRITE_COIL, ADDR_COIL_BASE, 16'h1234);
        check("coil_bad_exc", 32'(rx), 32'(EXC_VALUE));
        check("coil_bad_pin", 32'(dout_q), 32'h0);
        acc(8'h07, ADDR_STATUS, 16'h0000);
        check("func_exc", 32'(rx), 32'(EXC_FUNCTION));
        acc(FN_READ_INPUT, 16'h0fb5, 16'h0000);
        check("addr_exc", 32'(rx), 32'(EXC_ADDRESS));
        // remap defaults, then a new selection
        rd32(ADDR_SEL_ONE, v);
        check("remap_one", v, src_vals[0]);
        rd32(ADDR_SEL_TWO, v);
        check("remap_two", v, src_vals[1]);
        acc(FN_WRITE_HOLD, ADDR_REMAP_ONE, 16'h0004);
        rd32(ADDR_SEL_ONE, v);
        check("remap_sel", v, src_vals[4]);
        acc(FN_WRITE_HOLD, ADDR_FAULT, 16'h5a5a);
        check("hold_echo", 32'(rd), 32'h5a5a);
        acc(FN_READ_HOLD, ADDR_FAULT, 16'h0000);
        check("hold_read", 32'(rd), 32'h5a5a);
        wr_rd(ADDR_DOUT, 16'hc3c3);
        // accumulator reaching the limit exactly is not yet a fault
        acc(FN_WRITE_HOLD, ADDR_LIMIT_HI, 16'h0000);
        acc(FN_WRITE_HOLD, ADDR_LIMIT_LO, 16'h0010);
        acc(FN_WRITE_HOLD, ADDR_I2T_CLEAR, 16'h0001);
        acc(FN_WRITE_HOLD, ADDR_REMAP_TWO, {12'h000, SRC_I2T_ACC});
        @(posedge mclk);
        motor_running <= 1'b1;
        repeat (4) @(posedge mclk);
        motor_running <= 1'b0;
        rd32(ADDR_SEL_TWO, v);
        check("i2t_acc", v, 32'h0000_0010);
        rd32(ADDR_FAULT, v);
        check("i2t_at_limit", v, 32'h0);
        @(posedge mclk);
        motor_running <= 1'b1;
        @(posedge mclk);
        motor_running <= 1'b0;
        rd32(ADDR_SEL_TWO, v);
        check("i2t_frozen", v, 32'h0000_0014);
        rd32(ADDR_FAULT, v);
        check("i2t_fault", v, 32'h1 << FT_I2T);
        // clearing the accumulator also drops the fault
        acc(FN_WRITE_HOLD, ADDR_I2T_CLEAR, 16'h0001);
        rd32(ADDR_SEL_TWO, v);
        check("i2t_cleared", v, 32'h0);
        rd32(ADDR_FAULT, v);
        check("i2t_fault_gone", v, 32'h0);
        finish_test();
    end
endmodule // tb_mdr_regmap

// ===== rtl/mdr_hold_mem.sv
// holding register store with registered read data
module mdr_hold_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic mclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [15:0] rdata
);
    import mdr_pkg::*;

    logic [15:0] mem [DEPTH];

    // no reset on the array, contents are undefined until written
    always_ff @(posedge mclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // read data out of a register, one cycle after the address
    always_ff @(posedge mclk)
    begin
        rdata <= mem[raddr];
    end
endmodule // mdr_hold_mem

// ===== rtl/mdr_i2t.sv
// current squared time accumulator and limit fault
module mdr_i2t (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic running,
    input wire logic [15:0] cur_sq,
    input wire logic clear,
    input wire logic [31:0] limit,
    output logic [31:0] acc_q,
    output logic fault_q
);
    import mdr_pkg::*;

    logic [32:0] sum;

    assign sum = {1'b0, acc_q} + {17'h0_0000, cur_sq};

    // accumulate while running, saturate instead of wrapping
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            acc_q <= 32'h0000_0000;
        else if (clear)
            acc_q <= 32'h0000_0000;
        else if (running)
            acc_q <= sum[32] ? 32'hffff_ffff : sum[31:0];
    end

    // fault follows the comparison one cycle later
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            fault_q <= 1'b0;
        else
            fault_q <= (acc_q > limit);
    end

    a_acc_frozen : assert property (@(posedge mclk) disable iff (!rst_b)
        !running && !clear |=> acc_q == $past(acc_q))
        else $error("accumulator moved while motor idle");
endmodule // mdr_i2t

// ===== rtl/mdr_pkg.sv
// shared constants and carrier types of the drive register map
package mdr_pkg;
    // input register pair addresses, upper word at the lower address
    localparam logic [15:0] ADDR_POSITION = 16'h0fa1;
    localparam logic [15:0] ADDR_STATUS = 16'h0fa3;
    localparam logic [15:0] ADDR_FAULT = 16'h0fa5;
    localparam logic [15:0] ADDR_DIN = 16'h0fa7;
    localparam logic [15:0] ADDR_DOUT = 16'h0fa9;
    localparam logic [15:0] ADDR_SEL_ONE = 16'h0fab;
    localparam logic [15:0] ADDR_SEL_TWO = 16'h0fad;
    localparam logic [15:0] ADDR_INPUT_LAST = 16'h0fae;
    // holding register window and own control registers
    localparam logic [15:0] ADDR_HOLD_BASE = 16'h0fa1;
    localparam logic [15:0] ADDR_HOLD_LAST = 16'h0fb0;
    localparam logic [15:0] ADDR_REMAP_ONE = 16'h1388;
    localparam logic [15:0] ADDR_REMAP_TWO = 16'h1389;
    localparam logic [15:0] ADDR_LIMIT_HI = 16'h138a;
    localparam logic [15:0] ADDR_LIMIT_LO = 16'h138b;
    localparam logic [15:0] ADDR_I2T_CLEAR = 16'h138c;
    // coils
    localparam logic [15:0] ADDR_COIL_BASE = 16'h044c;
    localparam logic [15:0] ADDR_COIL_LAST = 16'h044f;
    localparam logic [15:0] COIL_ON = 16'hff00;
    localparam logic [15:0] COIL_OFF = 16'h0000;
    // function and exception codes
    localparam logic [7:0] FN_READ_COILS = 8'h01;
    localparam logic [7:0] FN_READ_HOLD = 8'h03;
    localparam logic [7:0] FN_READ_INPUT = 8'h04;
    localparam logic [7:0] FN_WRITE_COIL = 8'h05;
    localparam logic [7:0] FN_WRITE_HOLD = 8'h06;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    // status and fault bit positions
    localparam int ST_ENABLED = 0;
    localparam int ST_HOMED = 1;
    localparam int ST_MOVING = 2;
    localparam int ST_SW_STOP = 3;
    localparam int ST_BRAKE_FREE = 20;
    localparam int ST_IN_POSITION = 26;
    localparam int ST_HOST = 31;
    localparam int FT_I2T = 11;
    // remap source indices, reset selections and reset limit
    localparam logic [3:0] SRC_POS_ERR = 4'h3;
    localparam logic [3:0] SRC_I2T_ACC = 4'h9;
    localparam logic [3:0] SRC_I2T_LIMIT = 4'ha;
    localparam logic [3:0] SRC_DIN = 4'hd;
    localparam logic [3:0] SRC_DOUT = 4'he;
    localparam logic [3:0] REMAP_ONE_RST = 4'h0;
    localparam logic [3:0] REMAP_TWO_RST = 4'h1;
    localparam logic [31:0] I2T_LIMIT_RST = 32'h0100_0000;

    typedef struct packed {
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mdr_req_t;

    typedef struct packed {
        logic [15:0] data;
        logic [7:0] exc;
    } mdr_rsp_t;

    typedef struct packed {
        logic enabled;
        logic homed;
        logic moving;
        logic sw_stop;
        logic brake_released;
        logic in_position;
        logic host_control;
    } mdr_state_t;

    typedef struct packed {
        logic watchdog;
        logic short_circuit;
        logic flash;
        logic under_volt;
        logic over_volt;
        logic drive_temp;
        logic motor_temp;
        logic over_current;
        logic feedback;
        logic pos_error;
        logic sw_stop;
        logic neg_limit;
        logic pos_limit;
    } mdr_faults_t;
endpackage

// ===== rtl/mdr_regmap.sv
// drive register map: input words, coils, holding store, remap
module mdr_regmap #(
    parameter bit STEPPER = 1'b0,
    parameter int NUM_SRC = 15,
    parameter int NUM_DIN = 4,
    parameter int NUM_DOUT_IMG = 2,
    parameter int NUM_COIL = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire mdr_pkg::mdr_req_t req,
    output logic rsp_valid,
    output mdr_pkg::mdr_rsp_t rsp,
    input wire logic [31:0] position,
    input wire mdr_pkg::mdr_state_t state,
    input wire mdr_pkg::mdr_faults_t faults,
    input wire logic [NUM_DIN-1:0] din,
    input wire logic [31:0] src_vals [NUM_SRC],
    input wire logic encoder_fitted,
    input wire logic motor_running,
    input wire logic [15:0] cur_sq,
    output logic [NUM_COIL-1:0] dout_q
);
    import mdr_pkg::*;

    logic [3:0] remap_one_q;
    logic [3:0] remap_two_q;
    logic [31:0] limit_q;
    logic [31:0] i2t_acc;
    logic i2t_fault;
    logic [31:0] status_word;
    logic [31:0] fault_word;
    logic [31:0] din_word;
    logic [31:0] dout_word;
    logic [31:0] remap_one_word;
    logic [31:0] remap_two_word;
    logic [15:0] rd_word;
    logic [7:0] rd_exc;
    logic hold_wr;
    logic i2t_clear;
    logic [3:0] hold_idx;
    logic [15:0] hold_rdata;
    logic [1:0] coil_idx;
    logic rsp_valid_q;
    logic from_mem_q;
    mdr_rsp_t rsp_q;

    // a pair splits with the upper half at the lower address
    function automatic logic [15:0] half(input logic [31:0] v, input logic [15:0] a,
                                         input logic [15:0] base);
        return (a == base) ? v[31:16] : v[15:0];
    endfunction

    // source selection; stepper hides sources past its shorter list
    function automatic logic [31:0] pick(input logic [3:0] sel);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (sel == SRC_I2T_ACC && !STEPPER)
            v = i2t_acc;
        else if (sel == SRC_I2T_LIMIT && !STEPPER)
            v = limit_q;
        else if (sel == SRC_DIN)
            v = din_word;
        else if (sel == SRC_DOUT)
            v = dout_word;
        else if (STEPPER && sel == SRC_POS_ERR && !encoder_fitted)
            v = 32'h0000_0000;
        else if (32'(sel) < NUM_SRC && !(STEPPER && sel > SRC_I2T_LIMIT))
            v = src_vals[sel];
        return v;
    endfunction

    // status bitmap, internal-use positions held at zero
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_ENABLED] = state.enabled;
        status_word[ST_HOMED] = state.homed;
        status_word[ST_MOVING] = state.moving;
        status_word[ST_SW_STOP] = state.sw_stop;
        status_word[ST_BRAKE_FREE] = state.brake_released;
        status_word[ST_IN_POSITION] = state.in_position;
        status_word[ST_HOST] = state.host_control;
    end

    // fault bitmap, one means present; bits 14 and up reserved
    assign fault_word = {18'h0_0000, faults.watchdog, faults.short_circuit,
                         i2t_fault, faults.flash, faults.under_volt,
                         faults.over_volt, faults.drive_temp, faults.motor_temp,
                         faults.over_current, faults.feedback, faults.pos_error,
                         faults.sw_stop, faults.neg_limit, faults.pos_limit};

    // pin images carry only the used low bits
    assign din_word = {{(32-NUM_DIN){1'b0}}, din};
    assign dout_word = {{(32-NUM_DOUT_IMG){1'b0}}, dout_q[NUM_DOUT_IMG-1:0]};

    // a process rather than an assign: pick reads module signals that must wake it
    always_comb
    begin
        remap_one_word = pick(remap_one_q);
        remap_two_word = pick(remap_two_q);
    end

    mdr_i2t u_i2t (
        .mclk(mclk),
        .rst_b(rst_b),
        .running(motor_running),
        .cur_sq(cur_sq),
        .clear(i2t_clear),
        .limit(limit_q),
        .acc_q(i2t_acc),
        .fault_q(i2t_fault)
    );

    // write strobes decoded from the request
    assign hold_wr = req_valid && req.func == FN_WRITE_HOLD
                     && req.addr >= ADDR_HOLD_BASE && req.addr <= ADDR_HOLD_LAST;
    assign i2t_clear = req_valid && req.func == FN_WRITE_HOLD
                       && req.addr == ADDR_I2T_CLEAR;
    assign hold_idx = 4'(req.addr - ADDR_HOLD_BASE);
    assign coil_idx = 2'(req.addr - ADDR_COIL_BASE);

    mdr_hold_mem #(
        .DEPTH(16),
        .AW(4)
    ) u_hold (
        .mclk(mclk),
        .we(hold_wr),
        .waddr(hold_idx),
        .wdata(req.wdata),
        .raddr(hold_idx),
        .rdata(hold_rdata)
    );

    // read and write decode; exception code when refused
    always_comb
    begin
        rd_word = 16'h0000;
        rd_exc = EXC_NONE;
        if (req.func == FN_READ_INPUT)
        begin
            if (req.addr < ADDR_POSITION || req.addr > ADDR_INPUT_LAST)
                rd_exc = EXC_ADDRESS;
            else if (req.addr < ADDR_STATUS)
                rd_word = half(position, req.addr, ADDR_POSITION);
            else if (req.addr < ADDR_FAULT)
                rd_word = half(status_word, req.addr, ADDR_STATUS);
            else if (req.addr < ADDR_DIN)
                rd_word = half(fault_word, req.addr, ADDR_FAULT);
            else if (req.addr < ADDR_DOUT)
                rd_word = half(din_word, req.addr, ADDR_DIN);
            else if (req.addr < ADDR_SEL_ONE)
                rd_word = half(dout_word, req.addr, ADDR_DOUT);
            else if (req.addr < ADDR_SEL_TWO)
                rd_word = half(remap_one_word, req.addr, ADDR_SEL_ONE);
            else
                rd_word = half(remap_two_word, req.addr, ADDR_SEL_TWO);
        end
        else if (req.func == FN_READ_COILS || req.func == FN_WRITE_COIL)
        begin
            if (req.addr < ADDR_COIL_BASE || req.addr > ADDR_COIL_LAST)
                rd_exc = EXC_ADDRESS;
            else if (req.func == FN_WRITE_COIL && req.wdata != COIL_ON
                     && req.wdata != COIL_OFF)
                rd_exc = EXC_VALUE;
            else if (req.func == FN_WRITE_COIL)
                rd_word = req.wdata; // write answer echoes value
            else
                rd_word = {15'h0000, dout_q[coil_idx]};
        end
        else if (req.func == FN_READ_HOLD || req.func == FN_WRITE_HOLD)
        begin
            if (req.addr >= ADDR_HOLD_BASE && req.addr <= ADDR_HOLD_LAST)
                rd_word = req.wdata;
            else if (req.addr == ADDR_REMAP_ONE)
                rd_word = {12'h000, remap_one_q};
            else if (req.addr == ADDR_REMAP_TWO)
                rd_word = {12'h000, remap_two_q};
            else if (req.addr == ADDR_LIMIT_HI)
                rd_word = limit_q[31:16];
            else if (req.addr == ADDR_LIMIT_LO)
                rd_word = limit_q[15:0];
            else if (req.addr == ADDR_I2T_CLEAR)
                rd_word = 16'h0000;
            else
                rd_exc = EXC_ADDRESS;
            if (req.func == FN_WRITE_HOLD && rd_exc == EXC_NONE)
                rd_word = req.wdata;
        end
        else
        begin
            rd_exc = EXC_FUNCTION;
        end
    end

    // coils drive the outputs directly
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            dout_q <= '0;
        else if (req_valid && req.func == FN_WRITE_COIL && rd_exc == EXC_NONE)
            dout_q[coil_idx] <= (req.wdata == COIL_ON);
    end

    // remap selections, default analog input and analog output
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            remap_one_q <= REMAP_ONE_RST;
            remap_two_q <= REMAP_TWO_RST;
        end
        else if (req_valid && req.func == FN_WRITE_HOLD)
        begin
            if (req.addr == ADDR_REMAP_ONE)
                remap_one_q <= req.wdata[3:0];
            else if (req.addr == ADDR_REMAP_TWO)
                remap_two_q <= req.wdata[3:0];
        end
    end

    // limit is two halves; a limit change is not atomic across them
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            limit_q <= I2T_LIMIT_RST;
        else if (req_valid && req.func == FN_WRITE_HOLD)
        begin
            if (req.addr == ADDR_LIMIT_HI)
                limit_q[31:16] <= req.wdata;
            else if (req.addr == ADDR_LIMIT_LO)
                limit_q[15:0] <= req.wdata;
        end
    end

    // answer one cycle after the request
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rsp_valid_q <= 1'b0;
            from_mem_q <= 1'b0;
            rsp_q <= '0;
        end
        else
        begin
            rsp_valid_q <= req_valid;
            from_mem_q <= req_valid && req.func == FN_READ_HOLD
                          && req.addr >= ADDR_HOLD_BASE && req.addr <= ADDR_HOLD_LAST;
            if (req_valid)
                rsp_q <= '{data: rd_word, exc: rd_exc};
        end
    end

    // stored holding reads come straight from the memory register
    assign rsp_valid = rsp_valid_q;
    assign rsp = from_mem_q ? mdr_rsp_t'{data: hold_rdata, exc: EXC_NONE} : rsp_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_hold_write;
        req_valid && req.func == FN_WRITE_HOLD && hold_wr;
    endsequence

    sequence s_hold_read(logic [15:0] a);
        req_valid && req.func == FN_READ_HOLD && req.addr == a;
    endsequence

    sequence s_input_read(logic [15:0] a);
        req_valid && req.func == FN_READ_INPUT && req.addr == a;
    endsequence

    a_answer_latency : assert property (req_valid |=> rsp_valid)
        else $error("answer missing one cycle after request");
    a_answer_idle : assert property (!req_valid |=> !rsp_valid)
        else $error("answer without request");
    a_status_reserved : assert property ((status_word & 32'h7bef_fff0) == 32'h0000_0000)
        else $error("reserved status bit set");
    a_status_brake : assert property (status_word[ST_BRAKE_FREE] == state.brake_released
        && status_word[ST_IN_POSITION] == state.in_position)
        else $error("brake or position status wrong");
    a_status_host : assert property (status_word[ST_HOST] == state.host_control
        && status_word[ST_SW_STOP] == state.sw_stop)
        else $error("control or stop status wrong");
    a_fault_i2t : assert property (i2t_acc > limit_q |=> fault_word[FT_I2T])
        else $error("i2t fault not raised over limit");
    a_fault_order : assert property (fault_word[13:12] == {faults.watchdog,
        faults.short_circuit} && fault_word[31:14] == 18'h0_0000)
        else $error("fault bits 12 to 13 misplaced");
    a_coil_write : assert property (req_valid && req.func == FN_WRITE_COIL
        && req.wdata == COIL_ON && rd_exc == EXC_NONE |=> dout_q[$past(coil_idx)])
        else $error("coil write did not drive output");
    a_hold_store : assert property (s_hold_write ##1 s_hold_read($past(req.addr))
        |=> rsp.data == $past(req.wdata, 2))
        else $error("holding register readback differs");
    a_pin_images : assert property (din_word[31:NUM_DIN] == '0
        && dout_word[31:NUM_DOUT_IMG] == '0)
        else $error("unused image bits set");
    // answer and state checks; the position ones built from the request sequences
    a_position_upper : assert property (s_input_read(ADDR_POSITION)
        |=> rsp.data == $past(position[31:16]) && rsp.exc == EXC_NONE)
        else $error("position upper half wrong");
    a_position_lower : assert property (s_input_read(ADDR_POSITION + 16'h0001)
        |=> rsp.data == $past(position[15:0]) && rsp.exc == EXC_NONE)
        else $error("position lower half wrong");
    a_coil_refused : assert property (req_valid && req.func == FN_WRITE_COIL
        && rd_exc != EXC_NONE |=> $stable(dout_q))
        else $error("refused coil write moved an output");
    a_coil_readback : assert property (req_valid && req.func == FN_READ_COILS
        && rd_exc == EXC_NONE |=> rsp.data == {15'h0000, $past(dout_q[coil_idx])})
        else $error("coil read answer differs from output");
    a_i2t_clear : assert property (i2t_clear |=> i2t_acc == 32'h0000_0000)
        else $error("accumulator not cleared");
    a_fault_present : assert property (fault_word[FT_I2T] == i2t_fault
        && fault_word[0] == faults.pos_limit && fault_word[10] == faults.flash)
        else $error("fault bit does not follow its fault");
endmodule // mdr_regmap
